// ### rtl/ccm_ctrl.sv
// Purpose: switching-clock source choice, dither, pwm mode and buck load-current measurement
// Assumes: all inputs synchronous to clk_in; meas_adc_in holds the sensed current code
// Notes:   clock check counts sync edges per window; rates near 20 MHz and above alias
//          a measurement runs its full length from the last select write, so its timing is fixed
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/100ps

// Contract
// RL1: a select bit chooses which buck has its load current measured.
// RL2: any write to the select register starts a fresh measurement.
// RL3: measured buck is forced to pwm while measuring.
// RL4: a measurement finishes within 50 us of its trigger.
// RL5: finishing a measurement sets the measurement-done flag.
// RL6: a mask bit keeps the measurement-done flag off the interrupt.
// RL7: result is 9 bits: low byte in one register, msb in another.
// RL8: one result count is 20 mA, full scale 10.22 A.
// RL9: dither sweeps switching frequency between 0.85 nominal and nominal.
// RL10: dither only with rc source and pll off; applies to all three converters.
// RL11: sync enabled locks all three converters to the sync input clock.
// RL12: a 5-bit field gives the expected sync rate, 1 to 24 MHz.
// RL13: sync clock outside -30 % to +10 % of nominal counts as invalid.
// RL14: sync flag when sync clock expected but absent, including load to standby.
// RL15: sync flag on standby to active with sync on and no valid clock.
// RL16: a mask bit keeps the sync flag off the interrupt.
// RL17: auto mode runs pwm at heavy load, pfm at light load.
// RL18: forced pwm keeps fixed frequency at every load.
// RL19: the boost always runs forced pwm.
// RL20: step-up level code decodes to 4.9 V to 5.2 V in 0.1 V steps.
// RL21: boost or bypass mode fixed at load time, later changes ignored.
// RL22: with sync on, fall back to rc when clock invalid; sync off uses rc.
// RL23: standby flags clock loss or arrival, active flags only loss.
// RL24: old result holds until a new measurement ends, both parts together.
// RL25: after measuring, the buck returns to its configured mode.
module ccm_ctrl (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  input  wire logic        sync_timing_input_in,
  input  wire logic [2:0]  conv_en_in,
  input  wire logic        otp_pll_en_in,
  input  wire logic        otp_bypass_in,
  input  wire logic [8:0]  meas_adc_in,
  output logic      [1:0]  buck_fpwm_out,
  output logic             boost_fpwm_out,
  output logic             ext_clk_src_out,
  output logic             dither_on_out,
  output logic      [6:0]  dither_floor_pct_out,
  output logic      [12:0] step_up_mv_out,
  output logic             bypass_mode_out,
  output logic             host_irq_output_n_out
);

  // port carrier, whole state and its next value
  ccm_pkg::ccm_bus_t   bus;
  ccm_pkg::ccm_state_t s_r;
  ccm_pkg::ccm_state_t s_nxt;
  logic                fixed_r;
  logic [6:0]          floor_r;

  // gather the register port into one carrier
  assign bus.addr  = addr_in;
  assign bus.wdata = wdata_in;
  assign bus.wr    = wr_in;
  assign bus.rd    = rd_in;

  // next-state logic for the whole block
  // one pass fills every field; the flop block only registers it,
  // so reset values live in one place
  always_comb begin
    logic       any_en;
    logic       edge_now;
    logic [8:0] edges;
    logic       win_end;
    logic       valid_new;
    logic [1:0] set_f;
    logic [1:0] clr_f;
    logic       sel_wr;
    any_en    = |conv_en_in;
    edge_now  = sync_timing_input_in & ~s_r.sync_d;
    edges     = s_r.ecnt + {8'h00, edge_now};
    win_end   = (s_r.wcnt == 9'(ccm_pkg::WIN_CYC - 1));
    valid_new = s_r.valid;
    set_f     = 2'h0;
    clr_f     = 2'h0;
    sel_wr    = bus.wr && (bus.addr == ccm_pkg::REG_SEL);
    s_nxt     = s_r;

    // register writes
    // result, status and unmapped indices ignore writes
    if (bus.wr) begin
      case (bus.addr)
        ccm_pkg::REG_MODE: begin
          s_nxt.fpwm_cfg = bus.wdata[1:0];                                          // RL18
          s_nxt.dither   = bus.wdata[2];
        end
        ccm_pkg::REG_PLL: begin
          s_nxt.rate   = bus.wdata[4:0];                                            // RL12
          s_nxt.pll_en = bus.wdata[7];
        end
        ccm_pkg::REG_STEPUP: s_nxt.lvl  = bus.wdata[1:0];
        ccm_pkg::REG_SEL:    s_nxt.sel  = bus.wdata[0];                             // RL1
        ccm_pkg::REG_FLAGS:  clr_f      = bus.wdata[1:0];
        ccm_pkg::REG_MASK:   s_nxt.mask = bus.wdata[1:0];                           // RL6 RL16
        default: ;
      endcase
    end

    // measurement: restart on every select write, latch result at the end
    // a restart drops the running count; the old result stays put
    // the sensed code is taken once, at the last count
    if (sel_wr) begin
      s_nxt.busy = 1'b1;                                                            // RL2
      s_nxt.mcnt = 11'h000;
    end else if (s_r.busy) begin
      if (s_r.mcnt == 11'(ccm_pkg::MEAS_CYC - 1)) begin                             // RL4
        s_nxt.busy   = 1'b0;
        s_nxt.result = meas_adc_in;                                                 // RL7 RL8 RL24
        set_f[ccm_pkg::FLAG_MEAS] = 1'b1;                                           // RL5
      end else begin
        s_nxt.mcnt = s_r.mcnt + 11'h001;
      end
    end

    // sync clock check: count rising edges over a fixed window
    // the pin is sampled on clk_in, so fast rates alias
    // the verdict only moves at a window end or when the pll is disabled, which filters glitches
    // an empty window reads as a lost clock
    s_nxt.sync_d = sync_timing_input_in;
    if (win_end) begin
      s_nxt.wcnt = 9'h000;
      s_nxt.ecnt = 9'h000;
      valid_new  = s_r.pll_en
                   && (s_r.rate >= ccm_pkg::RATE_MIN_MHZ) && (s_r.rate <= ccm_pkg::RATE_MAX_MHZ)
                   && (edges >= ccm_pkg::rate_bound(s_r.rate, ccm_pkg::TOL_LO_TENTHS))
                   && (edges <= ccm_pkg::rate_bound(s_r.rate, ccm_pkg::TOL_HI_TENTHS));  // RL13
    end else begin
      s_nxt.wcnt = s_r.wcnt + 9'h001;
      s_nxt.ecnt = edges;
    end
    if (!s_r.pll_en) begin
      valid_new = 1'b0;                // detector off with pll disabled
    end
    s_nxt.valid = valid_new;

    // operating state and sync-clock events
    // load lasts one cycle: straps are read, then standby
    // a pll write in that cycle is lost under the strap
    case (s_r.st)
      ccm_pkg::ST_LOAD: begin
        s_nxt.pll_en = otp_pll_en_in;
        s_nxt.bypass = otp_bypass_in;                                               // RL21
        s_nxt.st     = ccm_pkg::ST_STANDBY;
        if (otp_pll_en_in) begin
          set_f[ccm_pkg::FLAG_SYNC] = 1'b1;                                         // RL14
        end
      end
      ccm_pkg::ST_STANDBY: begin
        if (s_r.pll_en && (valid_new != s_r.valid)) begin
          set_f[ccm_pkg::FLAG_SYNC] = 1'b1;                                         // RL23
        end
        if (any_en) begin
          s_nxt.st = ccm_pkg::ST_ACTIVE;
          if (s_r.pll_en && !s_r.valid) begin
            set_f[ccm_pkg::FLAG_SYNC] = 1'b1;                                       // RL15
          end
        end
      end
      ccm_pkg::ST_ACTIVE: begin
        if (s_r.pll_en && s_r.valid && !valid_new) begin
          set_f[ccm_pkg::FLAG_SYNC] = 1'b1;                                         // RL23 RL14
        end
        if (!any_en) begin
          s_nxt.st = ccm_pkg::ST_STANDBY;
        end
      end
      default: s_nxt.st = ccm_pkg::ST_LOAD;
    endcase

    // set wins over a clear in the same cycle
    // a racing clear must not hide an event from the host
    s_nxt.flags = (s_r.flags & ~clr_f) | set_f;

    // registered outputs
    // measuring forces pwm on the selected buck only;
    // the force drops one cycle after busy
    s_nxt.buck_fpwm[0] = s_r.fpwm_cfg[0] | (s_r.busy & ~s_r.sel);                   // RL3 RL17 RL25
    s_nxt.buck_fpwm[1] = s_r.fpwm_cfg[1] | (s_r.busy & s_r.sel);                    // RL3 RL17 RL25
    s_nxt.ext_src      = s_r.pll_en & s_r.valid;                                    // RL11 RL22
    s_nxt.dither_act   = s_r.dither & ~s_r.pll_en;                                  // RL9 RL10
    s_nxt.irq_n        = ~|(s_r.flags & ~s_r.mask);                                 // RL6 RL16
    s_nxt.step_mv      = ccm_pkg::step_up_mv(s_r.lvl);                              // RL20

    // read data stand only in the cycle after the strobe
    // idle and unmapped reads give zero
    s_nxt.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        ccm_pkg::REG_MODE:   s_nxt.rdata = {5'h00, s_r.dither, s_r.fpwm_cfg};
        ccm_pkg::REG_PLL:    s_nxt.rdata = {s_r.pll_en, 2'h0, s_r.rate};
        ccm_pkg::REG_STEPUP: s_nxt.rdata = {6'h00, s_r.lvl};
        ccm_pkg::REG_SEL:    s_nxt.rdata = {7'h00, s_r.sel};
        ccm_pkg::REG_FLAGS:  s_nxt.rdata = {6'h00, s_r.flags};
        ccm_pkg::REG_MASK:   s_nxt.rdata = {6'h00, s_r.mask};
        ccm_pkg::REG_RES_LO: s_nxt.rdata = s_r.result[7:0];                          // RL7
        ccm_pkg::REG_RES_HI: s_nxt.rdata = {7'h00, s_r.result[8]};                   // RL7
        ccm_pkg::REG_STAT:   s_nxt.rdata = {2'h0, s_r.bypass, s_r.st, s_r.ext_src, s_r.valid, s_r.busy};
        default:             s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // state register, synchronous reset
  // after the zero fill, st, fpwm_cfg, rate, lvl, mask, irq_n and step_mv are named
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_r            <= '0;
      s_r.st         <= ccm_pkg::ST_LOAD;
      s_r.fpwm_cfg   <= ccm_pkg::FPWM_RST;
      s_r.rate       <= ccm_pkg::RATE_RST;
      s_r.lvl        <= ccm_pkg::LVL_RST;
      s_r.mask       <= ccm_pkg::MASK_RST;
      s_r.irq_n      <= 1'b1;
      s_r.step_mv    <= ccm_pkg::STEP_UP_BASE_MV;
      fixed_r        <= 1'b0;
      floor_r        <= 7'h00;
    end else begin
      s_r            <= s_nxt;
      fixed_r        <= 1'b1;
      floor_r        <= ccm_pkg::DITHER_FLOOR_PCT;
    end
  end

  // outputs straight from flops; boost pwm and dither floor are constant after reset
  // both constants are flops so reset shows them low
  assign rdata_out             = s_r.rdata;
  assign buck_fpwm_out         = s_r.buck_fpwm;
  assign boost_fpwm_out        = fixed_r;                                           // RL19
  assign ext_clk_src_out       = s_r.ext_src;
  assign dither_on_out         = s_r.dither_act;
  assign dither_floor_pct_out  = floor_r;                                           // RL9
  assign step_up_mv_out        = s_r.step_mv;
  assign bypass_mode_out       = s_r.bypass;
  assign host_irq_output_n_out = s_r.irq_n;

  // checks: all on clk_in, idle in reset; registered outputs lag
  // their source by one edge, hence |=> with $past on the right
  localparam int MEAS_LAST = int'(ccm_pkg::MEAS_CYC) - 1;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence seq_sel_write;
    wr_in && (addr_in == ccm_pkg::REG_SEL);
  endsequence

  sequence seq_meas_end;
    s_r.busy && (s_r.mcnt == 11'(MEAS_LAST)) && !(wr_in && (addr_in == ccm_pkg::REG_SEL));
  endsequence

  // measurement sequence
  meas_restart_a: assert property (seq_sel_write |=> s_r.busy && (s_r.mcnt == 11'h000)) // RL2
    else $error("select write did not restart measurement");
  meas_bound_a: assert property (s_r.busy |-> (s_r.mcnt <= 11'(MEAS_LAST))) // RL4
    else $error("measurement ran past its limit");
  meas_done_a: assert property (seq_meas_end |=> !s_r.busy && s_r.flags[0] && (s_r.result == $past(meas_adc_in))) // RL5
    else $error("measurement end did not set flag and result");
  result_hold_a: assert property (!(s_r.busy && (s_r.mcnt == 11'(MEAS_LAST)) // RL24
                                    && !(wr_in && (addr_in == ccm_pkg::REG_SEL))) |=> $stable(s_r.result))
    else $error("result changed outside measurement end");
  force_pwm_a: assert property (s_r.busy |=> buck_fpwm_out[$past(s_r.sel)]) // RL3
    else $error("measured buck not forced to pwm");
  // interrupt gating
  irq_mask_a: assert property (|(s_r.flags & ~s_r.mask) |=> !host_irq_output_n_out) // RL6
    else $error("unmasked flag did not drive interrupt");
  irq_block_a: assert property (((s_r.flags & ~s_r.mask) == 2'h0) |=> host_irq_output_n_out) // RL16
    else $error("masked flag drove interrupt");
  // clock source and dither gating
  dither_gate_a: assert property (s_r.pll_en |=> !dither_on_out) // RL10
    else $error("dither active with pll enabled");
  ext_src_a: assert property (!(s_r.pll_en && s_r.valid) |=> !ext_clk_src_out) // RL22
    else $error("external clock used while invalid");
  // wake-up, straps and step-up level
  wake_flag_a: assert property ((s_r.st == ccm_pkg::ST_STANDBY) && (|conv_en_in) && s_r.pll_en && !s_r.valid
                                |=> s_r.flags[1] && (s_r.st == ccm_pkg::ST_ACTIVE)) // RL15
    else $error("wake without clock did not flag");
  bypass_fixed_a: assert property ((s_r.st != ccm_pkg::ST_LOAD) |=> $stable(bypass_mode_out)) // RL21
    else $error("bypass mode changed after load");
  step_level_a: assert property (1'b1 |=> step_up_mv_out == 13'(13'h1324 + 13'h0064 * $past(s_r.lvl))) // RL20
    else $error("step-up level decode wrong");

  // read strobes with the index beside them
  sequence seq_res_lo_read;
    rd_in && (addr_in == ccm_pkg::REG_RES_LO);
  endsequence

  sequence seq_res_hi_read;
    rd_in && (addr_in == ccm_pkg::REG_RES_HI);
  endsequence

  sequence seq_pll_read;
    rd_in && (addr_in == ccm_pkg::REG_PLL);
  endsequence

  // constants show one edge after release
  boost_pwm_a: assert property (1'b1 |=> boost_fpwm_out) // RL19
    else $error("boost left forced pwm");

  floor_fixed_a: assert property (1'b1 |=> dither_floor_pct_out == ccm_pkg::DITHER_FLOOR_PCT) // RL9
    else $error("dither floor wrong");

  // read data stand one cycle, zero otherwise
  rdata_idle_a: assert property (!rd_in |=> rdata_out == 8'h00) // RL7
    else $error("read data outside read cycle");

  // both result parts come from one stored word
  res_lo_read_a: assert property (seq_res_lo_read |=> rdata_out == $past(s_r.result[7:0])) // RL7
    else $error("result low byte read wrong");

  res_hi_read_a: assert property (seq_res_hi_read |=> rdata_out == {7'h00, $past(s_r.result[8])}) // RL7
    else $error("result msb read wrong");

  // rate reads back beside the pll enable
  rate_read_a: assert property (seq_pll_read // RL12
                                |=> rdata_out == {$past(s_r.pll_en), 2'h0, $past(s_r.rate)})
    else $error("rate field read wrong");

  // straps are taken once, in the load cycle
  load_capture_a: assert property ((s_r.st == ccm_pkg::ST_LOAD) // RL21
                                   |=> (s_r.st == ccm_pkg::ST_STANDBY) && (bypass_mode_out == $past(otp_bypass_in)))
    else $error("straps not captured on leaving load");

  // pll strap on means a clock is expected at once
  load_flag_a: assert property ((s_r.st == ccm_pkg::ST_LOAD) && otp_pll_en_in |=> s_r.flags[1]) // RL14
    else $error("no sync flag after load");

  // standby flags arrival and loss, active only loss
  arrive_flag_a: assert property ($rose(s_r.valid) && ($past(s_r.st) == ccm_pkg::ST_STANDBY) // RL23
                                  |-> s_r.flags[1])
    else $error("clock arrival in standby not flagged");

  // loss counts in both states
  loss_flag_a: assert property ($fell(s_r.valid) && $past(s_r.pll_en) |-> s_r.flags[1]) // RL23
    else $error("clock loss not flagged");

  // detector sleeps with the pll off; valid needs a rate in range
  valid_off_a: assert property (!s_r.pll_en |=> !s_r.valid) // RL22
    else $error("clock valid with pll off");

  valid_range_a: assert property ($rose(s_r.valid) // RL13
                                  |-> $past(s_r.pll_en) && ($past(s_r.rate) >= ccm_pkg::RATE_MIN_MHZ)
                                      && ($past(s_r.rate) <= ccm_pkg::RATE_MAX_MHZ))
    else $error("clock valid outside rate range");

  // a valid clock must be taken up
  ext_on_a: assert property (s_r.pll_en && s_r.valid |=> ext_clk_src_out) // RL11
    else $error("valid sync clock not used");

  // idle bucks follow their setting
  buck_cfg_a: assert property (!s_r.busy |=> buck_fpwm_out == $past(s_r.fpwm_cfg)) // RL18 RL25
    else $error("buck mode differs from setting");

  // dither runs whenever its gate allows
  dither_on_a: assert property (s_r.dither && !s_r.pll_en |=> dither_on_out) // RL9 RL10
    else $error("dither off on rc source");

  // only a select write may start a sequence
  meas_idle_a: assert property (!s_r.busy && !(wr_in && (addr_in == ccm_pkg::REG_SEL)) |=> !s_r.busy) // RL2
    else $error("measurement started without select write");

endmodule : ccm_ctrl

// ### pkg/ccm_pkg.sv
// Purpose: shared constants and types for the converter clock and load-measure control
// Assumes: 40 MHz system clock, 8-bit register port
// Notes:   register offsets are word indices on the plain register port
package ccm_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MEAS_MAX_NS   = 50000;                        // longest measurement, 50 us
  localparam int unsigned MEAS_CYC      = MEAS_MAX_NS / CLK_PERIOD_NS;  // rounds down
  localparam int unsigned WIN_NS        = 10000;                        // clock-check window, 10 us
  localparam int unsigned WIN_CYC       = WIN_NS / CLK_PERIOD_NS;

  // clock accuracy band in tenths of nominal: -30 % .. +10 %
  localparam logic [3:0] TOL_LO_TENTHS = 4'h7;
  localparam logic [3:0] TOL_HI_TENTHS = 4'hb;
  localparam logic [4:0] RATE_MIN_MHZ  = 5'h01;
  localparam logic [4:0] RATE_MAX_MHZ  = 5'h18;

  // load-current scaling: 20 mA per count, full scale 511 counts = 10.22 A
  localparam int unsigned LOAD_LSB_MA   = 20;
  localparam int unsigned LOAD_FS_MA    = 511 * LOAD_LSB_MA;
  // dither floor: 0.85 of nominal switching frequency
  localparam logic [6:0]  DITHER_FLOOR_PCT = 7'h55;
  // step-up level: 4900 mV base, 100 mV per code
  localparam logic [12:0] STEP_UP_BASE_MV  = 13'h1324;
  localparam logic [12:0] STEP_UP_STEP_MV  = 13'h0064;

  // register indices
  localparam logic [7:0] REG_MODE   = 8'h00;  // [0] buck0 fpwm [1] buck1 fpwm [2] freq_dither_on
  localparam logic [7:0] REG_PLL    = 8'h01;  // [4:0] ext_timing_nominal_rate [7] pll enable
  localparam logic [7:0] REG_STEPUP = 8'h02;  // [1:0] step_up_level_code
  localparam logic [7:0] REG_SEL    = 8'h03;  // [0] measured buck, write starts measurement
  localparam logic [7:0] REG_FLAGS  = 8'h04;  // [0] meas_done_flag [1] sync flag, write 1 clears
  localparam logic [7:0] REG_MASK   = 8'h05;  // [0] meas_done_irq_block [1] sync block
  localparam logic [7:0] REG_RES_LO = 8'h06;  // result [7:0]
  localparam logic [7:0] REG_RES_HI = 8'h07;  // [0] result [8]
  localparam logic [7:0] REG_STAT   = 8'h08;  // [0] busy [1] clk valid [2] ext source [4:3] state [5] bypass

  // reset values
  localparam logic [1:0] FPWM_RST  = 2'h0;
  localparam logic [4:0] RATE_RST  = 5'h01;
  localparam logic [1:0] LVL_RST   = 2'h0;
  localparam logic [1:0] MASK_RST  = 2'h0;

  // flag bit positions
  localparam int unsigned FLAG_MEAS = 0;
  localparam int unsigned FLAG_SYNC = 1;

  typedef enum logic [1:0] {
    ST_LOAD    = 2'b00,
    ST_STANDBY = 2'b01,
    ST_ACTIVE  = 2'b10
  } ccm_dev_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ccm_bus_t;

  typedef struct packed {
    ccm_dev_t    st;
    logic [1:0]  fpwm_cfg;
    logic        dither;
    logic        pll_en;
    logic [4:0]  rate;
    logic [1:0]  lvl;
    logic        sel;
    logic [1:0]  flags;
    logic [1:0]  mask;
    logic        busy;
    logic [10:0] mcnt;
    logic [8:0]  result;
    logic        bypass;
    logic        sync_d;
    logic [8:0]  wcnt;
    logic [8:0]  ecnt;
    logic        valid;
    logic [7:0]  rdata;
    logic [1:0]  buck_fpwm;
    logic        ext_src;
    logic        dither_act;
    logic        irq_n;
    logic [12:0] step_mv;
  } ccm_state_t;

  // edge-count bounds for one window at the given nominal rate
  function automatic logic [8:0] rate_bound(input logic [4:0] rate, input logic [3:0] tenths);
    logic [8:0] prod;
    prod = 9'(rate * tenths);
    return prod;
  endfunction : rate_bound

  // step-up output level in millivolts
  function automatic logic [12:0] step_up_mv(input logic [1:0] code);
    logic [12:0] v;
    v = STEP_UP_BASE_MV + 13'(code * STEP_UP_STEP_MV);
    return v;
  endfunction : step_up_mv

endpackage : ccm_pkg

// ### test/ccm_sync_src.sv
// Purpose: external sync clock source that drives the block's sync input
// Assumes: half period given in clk_in cycles, 0 stops the clock
// Notes:   idles low when stopped so a lost clock really looks lost
`timescale 1ns/100ps
module ccm_sync_src (
  input  wire logic       clk_in,
  input  wire logic [7:0] half_cyc_in,
  output logic            sync_out
);
  logic [7:0] cnt_r;

  // toggle every half period; caller picks in-band or out-of-band rate
  always @(posedge clk_in) begin
    if (half_cyc_in == 8'h00) begin
      sync_out <= 1'b0;
      cnt_r    <= 8'h00;
    end else if (cnt_r + 8'h01 >= half_cyc_in) begin
      sync_out <= ~sync_out;
      cnt_r    <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

endmodule : ccm_sync_src

// ### test/ccm_ctrl_tb.sv
// Purpose: self-checking bench for clock source, dither, pwm mode and load measurement
// Assumes: register map and latencies as handed over with the design
// Notes:   measurement timing checked at its full 2000-cycle length
`timescale 1ns/100ps
module ccm_ctrl_tb;
  logic        clk_in, rst_n_in, wr_in, rd_in, sync_w, otp_pll_en_in, otp_bypass_in;
  logic [7:0]  addr_in, wdata_in, rdata_out, half_r, d;
  logic [2:0]  conv_en_in;
  logic [8:0]  meas_adc_in;
  logic [1:0]  buck_fpwm_out;
  logic        boost_fpwm_out, ext_clk_src_out, dither_on_out, bypass_mode_out, host_irq_output_n_out;
  logic [6:0]  dither_floor_pct_out;
  logic [12:0] step_up_mv_out;
  int          n_fail, check_count;

  ccm_ctrl uut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .sync_timing_input_in(sync_w), .conv_en_in, .otp_pll_en_in, .otp_bypass_in, .meas_adc_in,
    .buck_fpwm_out, .boost_fpwm_out, .ext_clk_src_out, .dither_on_out, .dither_floor_pct_out,
    .step_up_mv_out, .bypass_mode_out, .host_irq_output_n_out);
  ccm_sync_src src (.clk_in(clk_in), .half_cyc_in(half_r), .sync_out(sync_w));

  // free-running 40 MHz clock
  always #12.5 clk_in = ~clk_in;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // one-cycle strobes, driven just after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  // bounded wait on the clock source choice
  task automatic wait_ext(input logic v);
    int i;
    for (i = 0; i < 1200 && ext_clk_src_out !== v; i++) cyc(1);
    chk(16'(ext_clk_src_out), 16'(v));
    if (i == 1200) final_report();
  endtask : wait_ext

  task automatic t_reset;
    cyc(3);
    chk(16'(host_irq_output_n_out), 16'h0);
    rd(ccm_pkg::REG_FLAGS, d);
    chk(16'(d), 16'h2);
    chk(16'({boost_fpwm_out, bypass_mode_out, dither_floor_pct_out}), 16'h1d5);
    otp_bypass_in <= 1'b0;
    cyc(3);
    chk(16'(bypass_mode_out), 16'h1);
    wr(ccm_pkg::REG_FLAGS, 8'h03);
    wr(ccm_pkg::REG_PLL, 8'h01);
    cyc(2);
    chk(16'(host_irq_output_n_out), 16'h1);
  endtask : t_reset

  task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
      wr(ccm_pkg::REG_STEPUP, 8'(i));
      cyc(2);
      chk(16'(step_up_mv_out), 16'(4900 + 100 * i));
    end
    wr(ccm_pkg::REG_MODE, 8'h05);
    cyc(2);
    chk(16'({buck_fpwm_out, dither_on_out}), 16'h3);
    wr(ccm_pkg::REG_PLL, 8'h98);
    cyc(2);
    chk(16'(dither_on_out), 16'h0);
    rd(ccm_pkg::REG_PLL, d);
    chk(16'(d), 16'h98);
    wr(ccm_pkg::REG_PLL, 8'h01);
    wr(ccm_pkg::REG_MODE, 8'h00);
    rd(8'h20, d);
    chk(16'(d), 16'h0);
    wr(ccm_pkg::REG_RES_LO, 8'hff);
    rd(ccm_pkg::REG_RES_LO, d);
    chk(16'(d), 16'h0);
  endtask : t_regs

  // full measurement; old result must hold until the end
  task automatic t_meas(input logic sel, input logic [8:0] adc, input logic blk, input logic [8:0] old);
    wr(ccm_pkg::REG_MASK, {7'h0, blk});
    meas_adc_in <= adc;
    wr(ccm_pkg::REG_SEL, {7'h0, sel});
    cyc(1);
    chk(16'(buck_fpwm_out), sel ? 16'h2 : 16'h1);
    rd(ccm_pkg::REG_RES_LO, d);
    chk(16'(d), 16'(old[7:0]));
    cyc(1997);
    chk(16'(host_irq_output_n_out), 16'h1);
    cyc(1);
    chk(16'(host_irq_output_n_out), 16'(blk));
    chk(16'(buck_fpwm_out), 16'h0);
    rd(ccm_pkg::REG_RES_LO, d);
    chk(16'(d), 16'(adc[7:0]));
    rd(ccm_pkg::REG_RES_HI, d);
    chk(16'(d), 16'(adc[8]));
    rd(ccm_pkg::REG_STAT, d);
    chk(16'(d[0]), 16'h0);
    rd(ccm_pkg::REG_FLAGS, d);
    chk(16'(d[0]), 16'h1);
    wr(ccm_pkg::REG_MASK, 8'h00);
    cyc(2);
    chk(16'(host_irq_output_n_out), 16'h0);
    wr(ccm_pkg::REG_FLAGS, 8'h03);
    cyc(2);
    chk(16'(host_irq_output_n_out), 16'h1);
  endtask : t_meas

  task automatic t_sync;
    wr(ccm_pkg::REG_PLL, 8'h82);
    half_r <= 8'd20;
    cyc(1000);
    chk(16'(ext_clk_src_out), 16'h0);
    half_r <= 8'd10;
    wait_ext(1'b1);
    rd(ccm_pkg::REG_FLAGS, d);
    chk(16'(d), 16'h2);
    wr(ccm_pkg::REG_FLAGS, 8'h03);
    conv_en_in <= 3'b001;
    cyc(10);
    chk(16'(host_irq_output_n_out), 16'h1);
    half_r <= 8'd0;
    wait_ext(1'b0);
    cyc(3);
    chk(16'(host_irq_output_n_out), 16'h0);
    conv_en_in <= 3'b000;
    cyc(5);
    wr(ccm_pkg::REG_MASK, 8'h02);
    wr(ccm_pkg::REG_FLAGS, 8'h03);
    conv_en_in <= 3'b100;
    cyc(5);
    chk(16'(host_irq_output_n_out), 16'h1);
    rd(ccm_pkg::REG_FLAGS, d);
    chk(16'(d), 16'h2);
    wr(ccm_pkg::REG_MASK, 8'h00);
    cyc(2);
    chk(16'(host_irq_output_n_out), 16'h0);
  endtask : t_sync

  // main sequence: reset for 20 cycles, then each scenario
  initial begin
    clk_in        = 1'b0;
    rst_n_in      = 1'b0;
    wr_in         = 1'b0;
    rd_in         = 1'b0;
    addr_in       = 8'h00;
    wdata_in      = 8'h00;
    otp_pll_en_in = 1'b1;
    otp_bypass_in = 1'b1;
    conv_en_in    = 3'h0;
    meas_adc_in   = 9'h000;
    half_r        = 8'h00;
    n_fail        = 0;
    check_count   = 0;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_regs();
    t_meas(1'b1, 9'h1ff, 1'b0, 9'h000);
    t_meas(1'b0, 9'h0a5, 1'b1, 9'h1ff);
    t_sync();
    final_report();
  end
endmodule : ccm_ctrl_tb
